// [hw/pcpa_top.sv]
// pcpa_top: cache mode decode, page attributes, write protect, alignment
// assumes: requests come from same-clock logic; entries already fetched
`timescale 1ns/1ps
`default_nettype none
module pcpa_top #(
	parameter int CACHE_SIZE = pcpa_pkg::CACHE_BYTES
) (
	input wire logic CLOCK,
	input wire logic RST,
	input wire logic [31:0] CONTROL_WORD,
	input wire logic [31:0] BASE_WORD,
	input wire logic [31:0] FLAGS_WORD,
	input wire logic [31:0] DIR_ENTRY,
	input wire logic [31:0] TABLE_ENTRY,
	input wire logic CACHE_ALLOW_INPUT,
	input wire pcpa_pkg::pcpa_req_type REQ,
	output pcpa_pkg::pcpa_rsp_type RSP,
	output logic RSP_VALID,
	output logic ACCESS_GRANTED,
	output logic PAGE_WRITE_POLICY_ATTR,
	output logic PAGE_NOCACHE_ATTR,
	output logic CACHE_LINE_ALLOC,
	output logic RESERVED_MODE
);
	// unified cache size is fixed by the structure around this block
	if (CACHE_SIZE != pcpa_pkg::CACHE_BYTES) begin : g_size_check
		$error("pcpa_top: unified cache must be 8KB");
	end

	pcpa_pkg::pcpa_rsp_type rsp_reg, rsp_next;
	logic valid_reg, valid_next;
	logic grant_reg, grant_next;
	logic policy_reg, policy_next;
	logic nocache_reg, nocache_next;
	logic alloc_reg, alloc_next;
	logic resv_reg, resv_next;

	logic fill_inhibit;
	logic wt_suppress;
	logic [31:0] attr_src;
	logic entry_user;
	logic entry_writable;
	logic write_protect;
	logic supervisor;
	logic misaligned;
	logic prot_fault;
	logic align_fault;

	always_comb begin
		fill_inhibit = CONTROL_WORD[pcpa_pkg::FILL_INHIBIT_BIT];
		wt_suppress = CONTROL_WORD[pcpa_pkg::WT_SUPPRESS_BIT];
		write_protect = CONTROL_WORD[pcpa_pkg::WRITE_PROTECT_BIT];
		supervisor = (REQ.level != pcpa_pkg::USER_LEVEL);
		// attribute source by cycle kind
		unique case (REQ.src)
			pcpa_pkg::PCPA_SRC_BASE: attr_src = BASE_WORD;
			pcpa_pkg::PCPA_SRC_DIR: attr_src = DIR_ENTRY;
			default: attr_src = TABLE_ENTRY;
		endcase
		// effective rights are the more restrictive of the two levels
		entry_user = DIR_ENTRY[pcpa_pkg::ENTRY_USER_BIT]
			& TABLE_ENTRY[pcpa_pkg::ENTRY_USER_BIT];
		entry_writable = DIR_ENTRY[pcpa_pkg::ENTRY_WRITABLE_BIT]
			& TABLE_ENTRY[pcpa_pkg::ENTRY_WRITABLE_BIT];
		// misalignment by access size
		unique case (REQ.size)
			pcpa_pkg::PCPA_SZ_WORD: misaligned = REQ.addr[0];
			pcpa_pkg::PCPA_SZ_DWORD: misaligned = |REQ.addr[1:0];
			pcpa_pkg::PCPA_SZ_QWORD: misaligned = |REQ.addr[2:0];
			pcpa_pkg::PCPA_SZ_BYTE: misaligned = 1'b0;
		endcase
		// protection check
		if (supervisor) begin
			// compatible mode lets supervisor write anything
			prot_fault = REQ.write & write_protect & ~entry_writable;
		end else begin
			prot_fault = ~entry_user | (REQ.write & ~entry_writable);
		end
		// alignment check, data references only
		align_fault = CONTROL_WORD[pcpa_pkg::ALIGN_MASK_BIT]
			& FLAGS_WORD[pcpa_pkg::FLAG_ALIGN_BIT]
			& ~supervisor
			& ~REQ.fetch & misaligned;
	end

	always_comb begin
		rsp_next = rsp_reg;
		valid_next = 1'b0;
		grant_next = 1'b0;
		policy_next = policy_reg;
		nocache_next = nocache_reg;
		alloc_next = 1'b0;
		resv_next = ~fill_inhibit & wt_suppress;
		if (REQ.valid) begin
			valid_next = 1'b1;
			policy_next = attr_src[pcpa_pkg::WRITE_POLICY_BIT];
			nocache_next = attr_src[pcpa_pkg::NOCACHE_BIT];
			// internal cache writes through unless WT_SUPPRESS_BIT is set; policy bit not used here
			rsp_next.write_through = ~wt_suppress;
			rsp_next.invalidate_ok = ~wt_suppress;
			rsp_next.fill_ok = ~fill_inhibit & CACHE_ALLOW_INPUT
				& ~attr_src[pcpa_pkg::NOCACHE_BIT];
			// alignment reported ahead of page fault, before completion
			if (align_fault) begin
				rsp_next.fault = 1'b1;
				rsp_next.vector = pcpa_pkg::ALIGN_FAULT_VEC;
				rsp_next.err_code = pcpa_pkg::ALIGN_ERR_CODE;
			end else if (prot_fault) begin
				rsp_next.fault = 1'b1;
				rsp_next.vector = pcpa_pkg::PAGE_FAULT_VEC;
				rsp_next.err_code = {13'h0, supervisor ? 1'b0 : 1'b1,
					REQ.write, 1'b1};
			end else begin
				rsp_next.fault = 1'b0;
				rsp_next.vector = 8'h00;
				rsp_next.err_code = 16'h0000;
			end
			grant_next = ~align_fault & ~prot_fault;
			// line fill only when allowed; results unchanged either way
			alloc_next = grant_next & ~REQ.write & rsp_next.fill_ok;
		end
	end

	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			rsp_reg <= '0;
			valid_reg <= 1'b0;
			grant_reg <= 1'b0;
			policy_reg <= 1'b0;
			nocache_reg <= 1'b0;
			alloc_reg <= 1'b0;
			resv_reg <= 1'b0;
		end else begin
			rsp_reg <= rsp_next;
			valid_reg <= valid_next;
			grant_reg <= grant_next;
			policy_reg <= policy_next;
			nocache_reg <= nocache_next;
			alloc_reg <= alloc_next;
			resv_reg <= resv_next;
		end
	end

	assign RSP = rsp_reg;
	assign RSP_VALID = valid_reg;
	assign ACCESS_GRANTED = grant_reg;
	assign PAGE_WRITE_POLICY_ATTR = policy_reg;
	assign PAGE_NOCACHE_ATTR = nocache_reg;
	assign CACHE_LINE_ALLOC = alloc_reg;
	assign RESERVED_MODE = resv_reg;
endmodule : pcpa_top
`default_nettype wire

// [hw/pcpa_pkg.sv]
// pcpa_pkg: constants and carriers for page cache, protection and alignment
// assumes: used by hw/pcpa_top.sv, the checker and the testbench, through scoped names
package pcpa_pkg;
	localparam int CTRL_W = 32;
	localparam int FILL_INHIBIT_BIT = 30;
	localparam int WT_SUPPRESS_BIT = 29;
	localparam int ALIGN_MASK_BIT = 18;
	localparam int WRITE_PROTECT_BIT = 16;
	localparam int FLAG_ALIGN_BIT = 18;
	localparam int ENTRY_WRITABLE_BIT = 1;
	localparam int ENTRY_USER_BIT = 2;
	localparam int NOCACHE_BIT = 3;
	localparam int WRITE_POLICY_BIT = 4;
	localparam logic [7:0] PAGE_FAULT_VEC = 8'h0E;
	localparam logic [7:0] ALIGN_FAULT_VEC = 8'h11;
	localparam logic [15:0] ALIGN_ERR_CODE = 16'h0000;
	localparam logic [1:0] USER_LEVEL = 2'h3;
	localparam int CACHE_BYTES = 8192;
	localparam int PAGE_BYTES = 4096;

	typedef enum logic [1:0] {
		PCPA_SZ_BYTE = 2'h0,
		PCPA_SZ_WORD = 2'h1,
		PCPA_SZ_DWORD = 2'h2,
		PCPA_SZ_QWORD = 2'h3
	} pcpa_size_type;

	typedef enum logic [1:0] {
		PCPA_SRC_BASE = 2'h0,
		PCPA_SRC_DIR = 2'h1,
		PCPA_SRC_TABLE = 2'h2
	} pcpa_src_type;

	typedef struct packed {
		logic valid;
		logic write;
		logic fetch;
		logic [1:0] level;
		pcpa_size_type size;
		pcpa_src_type src;
		logic [31:0] addr;
	} pcpa_req_type;

	typedef struct packed {
		logic fill_ok;
		logic write_through;
		logic invalidate_ok;
		logic fault;
		logic [7:0] vector;
		logic [15:0] err_code;
	} pcpa_rsp_type;
endpackage : pcpa_pkg

// [verif/pcpa_properties.sv]
// pcpa_chk: port checks of pcpa_top
// assumes: one clock domain, bound below
`timescale 1ns/1ps
`default_nettype none
module pcpa_chk (
	input wire logic CLOCK,
	input wire logic RST,
	input wire logic [31:0] CONTROL_WORD,
	input wire logic [31:0] BASE_WORD,
	input wire logic [31:0] FLAGS_WORD,
	input wire logic [31:0] TABLE_ENTRY,
	input wire pcpa_pkg::pcpa_req_type REQ,
	input wire pcpa_pkg::pcpa_rsp_type RSP,
	input wire logic RSP_VALID,
	input wire logic PAGE_WRITE_POLICY_ATTR,
	input wire logic PAGE_NOCACHE_ATTR
);
	default clocking @(posedge CLOCK);
	endclocking
	default disable iff (RST);
	a_answer_pulse: assert property (REQ.valid |=> RSP_VALID)
		else $error("no answer");
	a_wt_follow: assert property (REQ.valid |=>
		RSP.write_through != $past(CONTROL_WORD[29]) &&
		RSP.invalidate_ok == RSP.write_through) else $error("wt");
	a_fill_off: assert property (REQ.valid && CONTROL_WORD[30] |=>
		!RSP.fill_ok) else $error("fill");
	a_nocache_fill: assert property (RSP_VALID && PAGE_NOCACHE_ATTR |->
		!RSP.fill_ok) else $error("nocache");
	a_policy_src: assert property (REQ.valid && REQ.src == 2'h0 |=>
		PAGE_WRITE_POLICY_ATTR == $past(BASE_WORD[4])) else $error("pwp");
	a_align_fault: assert property (REQ.valid && !REQ.fetch &&
		REQ.level == 2'h3 && CONTROL_WORD[18] && FLAGS_WORD[18] &&
		REQ.size == 2'h1 && REQ.addr[0] |=> RSP.fault &&
		RSP.vector == 8'h11 && RSP.err_code == 16'h0000) else $error("al");
	a_align_level: assert property (REQ.valid && !REQ.write &&
		REQ.level != 2'h3 |=> !RSP.fault) else $error("level");
	a_wp_fault: assert property (REQ.valid && REQ.write &&
		REQ.level != 2'h3 && CONTROL_WORD[16] && !TABLE_ENTRY[1] |=>
		RSP.fault && RSP.vector == 8'h0E) else $error("wp");
endmodule : pcpa_chk
bind pcpa_top pcpa_chk chk_u (.CLOCK, .RST, .CONTROL_WORD, .BASE_WORD,
	.FLAGS_WORD, .TABLE_ENTRY, .REQ, .RSP, .RSP_VALID,
	.PAGE_WRITE_POLICY_ATTR, .PAGE_NOCACHE_ATTR);
`default_nettype wire

// [verif/pcpa_l2_model.sv]
// pcpa_l2_model: outer cache granting the allow pin
// assumes: same clock, grant one cycle late
`timescale 1ns/1ps
`default_nettype none
module pcpa_l2_model (
	input wire logic clk,
	input wire logic allow_en,
	output logic allow
);
	always_ff @(posedge clk) begin
		allow <= allow_en;
	end
endmodule : pcpa_l2_model
`default_nettype wire

// [verif/tb_page_cache_protect_align.sv]
// tb_page_cache_protect_align: directed scenarios for pcpa_top
// assumes: checker bound by its own file
`timescale 1ns/1ps
`default_nettype none
module tb_page_cache_protect_align;
	logic clk, rst, allow_en, allow, rv, ag, pwp, pnc, cla, rm;
	logic [31:0] cw, bw, fw, de, te;
	pcpa_pkg::pcpa_req_type req;
	pcpa_pkg::pcpa_rsp_type rsp;
	int errors = 0;
	int n_tests = 0;
	pcpa_top dut_u (.CLOCK(clk), .RST(rst), .CONTROL_WORD(cw),
		.BASE_WORD(bw), .FLAGS_WORD(fw), .DIR_ENTRY(de), .TABLE_ENTRY(te),
		.CACHE_ALLOW_INPUT(allow), .REQ(req), .RSP(rsp), .RSP_VALID(rv),
		.ACCESS_GRANTED(ag), .PAGE_WRITE_POLICY_ATTR(pwp),
		.PAGE_NOCACHE_ATTR(pnc), .CACHE_LINE_ALLOC(cla), .RESERVED_MODE(rm));
	pcpa_l2_model l2_u (.clk(clk), .allow_en(allow_en), .allow(allow));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH %0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic go(input logic [31:0] c, input logic wr,
		input logic [1:0] lv, input logic [1:0] sz, input logic [1:0] src,
		input logic [31:0] a);
		@(posedge clk);
		cw <= c;
		req <= {1'b1, wr, 1'b0, lv, sz, src, a};
		@(posedge clk);
		req.valid <= 1'b0;
		#1;
		chk(rv, 1'b1);
	endtask : go
	task automatic t_modes();
		for (int i = 0; i < 4; i++) begin
			if (i != 1) begin
				go({1'b0, 2'(i), 29'h0}, 1'b0, 2'h0, 2'h2, 2'h0, 32'h0);
				chk(rsp.fill_ok, i < 2);
				chk(rsp.write_through, i[0] == 1'b0);
				chk(rm, 1'b0);
			end
		end
		$display("modes done");
	endtask : t_modes
	task automatic t_attrs();
		for (int s = 0; s < 3; s++) begin
			go(32'h0, 1'b0, 2'h0, 2'h2, 2'(s), 32'h0);
			chk({pwp, pnc, rsp.fill_ok}, s == 1 ? 3'h2 : 3'h5);
		end
		@(posedge clk);
		allow_en <= 1'b0;
		go(32'h0, 1'b0, 2'h0, 2'h2, 2'h0, 32'h0);
		chk(rsp.fill_ok, 1'b0);
		@(posedge clk);
		allow_en <= 1'b1;
		$display("attrs done");
	endtask : t_attrs
	task automatic t_protect();
		for (int w = 0; w < 2; w++) begin
			go(32'(w) << 16, 1'b1, 2'h0, 2'h2, 2'h2, 32'h0);
			chk({rsp.fault, ag}, w == 1 ? 2'h2 : 2'h1);
			go(32'(w) << 16, 1'b1, 2'h3, 2'h2, 2'h2, 32'h0);
			chk({rsp.fault, rsp.vector}, 9'h10E);
		end
		$display("protect done");
	endtask : t_protect
	task automatic al(input logic mk, input logic [1:0] lv,
		input logic [1:0] sz, input logic [31:0] a, input logic e);
		go({13'h0, mk, 18'h0}, 1'b0, lv, sz, 2'h2, a);
		chk(rsp.fault, e);
		chk(rsp.vector, e ? 8'h11 : 8'h00);
	endtask : al
	task automatic t_align();
		al(1'b1, 2'h3, 2'h1, 32'h1, 1'b1);
		al(1'b0, 2'h3, 2'h1, 32'h1, 1'b0);
		al(1'b1, 2'h0, 2'h1, 32'h1, 1'b0);
		al(1'b1, 2'h3, 2'h2, 32'h2, 1'b1);
		al(1'b1, 2'h3, 2'h3, 32'h4, 1'b1);
		al(1'b1, 2'h3, 2'h3, 32'h8, 1'b0);
		al(1'b1, 2'h3, 2'h0, 32'h1, 1'b0);
		$display("align done");
	endtask : t_align
	task automatic report_and_stop();
		$display("tests %0d errors %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : report_and_stop
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		#5000;
		errors++;
		report_and_stop();
	end
	initial begin
		rst = 1'b1;
		cw = 32'h0;
		bw = 32'h10;
		fw = 32'h40000;
		de = 32'hE;
		te = 32'h14;
		allow_en = 1'b1;
		req = '0;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		t_modes();
		t_attrs();
		t_protect();
		t_align();
		report_and_stop();
	end
endmodule : tb_page_cache_protect_align
`default_nettype wire
